// file: design/pcs_pkg.sv
// pcs_pkg: constants and types of the clock synthesizer control block.
// assumes one 250 MHz system clock; all pin inputs are sampled on it.
`default_nettype none
package pcs_pkg;
    localparam int unsigned PCS_AW = 24;
    localparam int unsigned PCS_DW = 16;
    // register byte offsets below the mapped nibble
    localparam logic [19:0] PCS_CTL_OFS = 20'hFFA04;
    localparam logic [19:0] PCS_ISR_OFS = 20'hFFA40;
    localparam logic [19:0] PCS_IMR_OFS = 20'hFFA42;
    localparam logic [2:0] PCS_MAP_ONES = 3'h7;
    // control register layout and reset value
    localparam logic [15:0] PCS_CTL_RST = 16'h3F00;
    localparam logic [15:0] PCS_CTL_WMASK = 16'hFF00;
    localparam int PCS_W_BIT = 15;
    localparam int PCS_X_BIT = 14;
    localparam int PCS_Y_LSB = 8;
    localparam int PCS_Y_W = 6;
    localparam int PCS_LOCK_BIT = 3;
    // feedback prescaler: vco/16, or vco/64 with the prescaler bit set
    localparam logic [5:0] PCS_PRE_LAST_W0 = 6'h0F;
    localparam logic [5:0] PCS_PRE_LAST_W1 = 6'h3F;
    // output divider: vco/4, or vco/2 with the output divider bit set
    localparam logic [1:0] PCS_ODIV_LAST_X0 = 2'h3;
    localparam logic [1:0] PCS_ODIV_LAST_X1 = 2'h1;
    // interrupt events
    localparam int PCS_EV_N = 2;
    localparam int PCS_EV_LOCK = 0;
    localparam int PCS_EV_UNLOCK = 1;
    localparam logic [1:0] PCS_EV_RST = 2'h0;
    // lock detection
    localparam int PCS_LOCK_WIN = 32;
    localparam int PCS_LOCK_GOOD = 2;
    typedef enum logic {PCS_SRC_EXT, PCS_SRC_SYNTH} pcs_src_t;
endpackage
`default_nettype wire

// file: design/pcs_pll_if.sv
// pcs_pll_if: edges, divider setup and lock between control and loop logic.
// all signals are single-cycle pulses or levels on the one system clock.
`default_nettype none
interface pcs_pll_if;
    logic vco_edge;
    logic ref_edge;
    logic fb_w;
    logic [5:0] fb_y;
    logic relock;
    logic fb_pulse;
    logic locked;
    modport div (input vco_edge, fb_w, fb_y, relock, output fb_pulse);
    modport det (input ref_edge, fb_pulse, relock, output locked);
    modport ctl (output vco_edge, ref_edge, fb_w, fb_y, relock,
                 input fb_pulse, locked);
endinterface
`default_nettype wire

// file: design/pcs_fbdiv.sv
// pcs_fbdiv: feedback divider, prescaler then down counter reloaded from fb_y, dividing by fb_y+1.
// assumes vco_edge is one pulse per sampled vco rising edge.
`default_nettype none
module pcs_fbdiv
    import pcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    pcs_pll_if.div pll
);
    logic [5:0] pre_r;
    logic [5:0] mod_r;
    logic fb_r;
    wire logic [5:0] pre_last = pll.fb_w ? PCS_PRE_LAST_W1 : PCS_PRE_LAST_W0;
    wire logic pre_wrap = pll.vco_edge && (pre_r == pre_last);
    wire logic mod_zero = (mod_r == 6'h00);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_r <= 6'h00;
            mod_r <= 6'h3F;
            fb_r <= 1'b0;
        end
        else if (pll.relock)
        begin
            pre_r <= 6'h00;
            mod_r <= pll.fb_y;
            fb_r <= 1'b0;
        end
        else
        begin
            if (pll.vco_edge)
                pre_r <= pre_wrap ? 6'h00 : pre_r + 6'h01;
            if (pre_wrap)
                mod_r <= mod_zero ? pll.fb_y : mod_r - 6'h01;
            fb_r <= pre_wrap && mod_zero;
        end
    end
    assign pll.fb_pulse = fb_r;

    property p_prescale;
        @(posedge clk) disable iff (!rst_n)
        (pll.vco_edge && !pll.relock && !pll.fb_w && pre_r == 6'h0F)
            |=> (pre_r == 6'h00);
    endproperty
    a_prescale: assert property (p_prescale)
        else $error("prescaler did not wrap at its limit");

    property p_reload;
        @(posedge clk) disable iff (!rst_n)
        (pre_wrap && mod_zero && !pll.relock)
            |=> (mod_r == $past(pll.fb_y)) && fb_r;
    endproperty
    a_reload: assert property (p_reload)
        else $error("modulus counter did not reload");
endmodule
`default_nettype wire

// file: design/pcs_lockdet.sv
// pcs_lockdet: frequency lock detector over windows of reference cycles.
// locks after GOOD windows with equal counts; one bad window unlocks.
`default_nettype none
module pcs_lockdet
    import pcs_pkg::*;
#(
    parameter int WIN = PCS_LOCK_WIN,
    parameter int GOOD = PCS_LOCK_GOOD
)
(
    input wire logic clk,
    input wire logic rst_n,
    pcs_pll_if.det pll
);
    typedef enum logic {LD_ACQ, LD_LOCK} pcs_ld_t;
    pcs_ld_t st_r;
    logic [7:0] win_r;
    logic [7:0] fbc_r;
    logic [3:0] good_r;
    wire logic win_end = pll.ref_edge && (win_r == 8'(WIN - 1));
    wire logic [7:0] fb_now = fbc_r + {7'h00, pll.fb_pulse};
    wire logic match = (fb_now == 8'(WIN));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_r <= 8'h00;
            fbc_r <= 8'h00;
        end
        else if (pll.relock || win_end)
        begin
            win_r <= 8'h00;
            fbc_r <= 8'h00;
        end
        else
        begin
            if (pll.ref_edge)
                win_r <= win_r + 8'h01;
            if (pll.fb_pulse && fbc_r != 8'hFF)
                fbc_r <= fb_now;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= LD_ACQ;
            good_r <= 4'h0;
        end
        else if (pll.relock)
        begin
            st_r <= LD_ACQ;
            good_r <= 4'h0;
        end
        else if (win_end)
        begin
            unique case (st_r)
                LD_ACQ:
                begin
                    good_r <= match ? good_r + 4'h1 : 4'h0;
                    if (match && good_r == 4'(GOOD - 1))
                        st_r <= LD_LOCK;
                end
                LD_LOCK:
                begin
                    if (!match)
                    begin
                        st_r <= LD_ACQ;
                        good_r <= 4'h0;
                    end
                end
            endcase
        end
    end
    assign pll.locked = (st_r == LD_LOCK);

    property p_lock_needs_match;
        @(posedge clk) disable iff (!rst_n)
        $rose(pll.locked) |-> $past(win_end && match);
    endproperty
    a_lock_needs_match: assert property (p_lock_needs_match)
        else $error("lock declared without matching window");
endmodule
`default_nettype wire

// file: design/pcs_top.sv
// pcs_top: clock synthesizer control register, dividers, lock and reset hold.
// assumes pins are asynchronous to clk and much slower than 125 MHz.
// How it works
// - output divider bit halves output division, no relock
// - prescaler bit selects four-times deeper feedback prescale
// - modulus field reloads down counter, divides by field+1
// - changing prescaler bit or modulus forces relock
// - output frequency follows reference times programmed ratio, or equals reference with external source
// - vco runs 2x or 4x output clock
// - lock when divided feedback matches reference, or at once with external source
// - lock status bit readable in control register
// - device reset held until synthesizer locks, or with external source only until the source is latched
// - register readable only at supervisor level
// - control register resets to 3F00
// - upper address nibble is map bit then ones
// - clock source pin sampled while reset held
// - prescaler bit15, divider bit14, modulus bits 13-8
`default_nettype none
module pcs_top
    import pcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [pcs_pkg::PCS_AW-1:0] addr,
    input wire logic [pcs_pkg::PCS_DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [pcs_pkg::PCS_DW-1:0] rdata,
    input wire logic supervisor,
    input wire logic module_map_bit,
    input wire logic reference_clock_input,
    input wire logic vco_clk_in,
    input wire logic clock_source_select_pin,
    output logic fb_compare,
    output logic sys_clk_en,
    output logic sys_rst_n,
    output logic locked,
    output logic irq
);
    import pcs_pkg::*;

    localparam int NPIN = 3;
    localparam int PIN_REF = 0;
    localparam int PIN_VCO = 1;
    localparam int PIN_SRC = 2;

    // pin levels read low until the synchronisers have filled, so the
    // source pin is trusted only after that; a high pin would otherwise
    // look like the external source for the first few cycles of reset
    localparam logic [2:0] SYNC_FILL = 3'h4;

    pcs_pll_if pll ();

    logic [2:0] fill_r;
    wire logic pins_valid = (fill_r == SYNC_FILL);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fill_r <= 3'h0;
        else if (!pins_valid)
            fill_r <= fill_r + 3'h1;
    end

    // pin synchronisers: three flops, a change counts once 2nd and 3rd agree
    wire logic [NPIN-1:0] pin_in = {clock_source_select_pin, vco_clk_in,
                                    reference_clock_input};
    logic [NPIN-1:0] pin_lvl;
    logic [NPIN-1:0] pin_rise;
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            logic [2:0] sh_r;
            logic lvl_r;
            logic rise_r;
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    sh_r <= 3'h0;
                    lvl_r <= 1'b0;
                    rise_r <= 1'b0;
                end
                else
                begin
                    sh_r <= {sh_r[1:0], pin_in[gi]};
                    rise_r <= 1'b0;
                    if (sh_r[1] == sh_r[2] && sh_r[2] != lvl_r)
                    begin
                        lvl_r <= sh_r[2];
                        rise_r <= sh_r[2];
                    end
                end
            end
            assign pin_lvl[gi] = lvl_r;
            assign pin_rise[gi] = rise_r;
        end
    endgenerate

    // address decode, upper nibble follows the module map bit
    function automatic logic hit(input logic [PCS_AW-1:0] a,
                                 input logic mm,
                                 input logic [19:0] ofs);
        hit = (a[23:20] == {mm, PCS_MAP_ONES}) && (a[19:0] == ofs);
    endfunction

    wire logic sel_ctl = hit(addr, module_map_bit, PCS_CTL_OFS);
    wire logic sel_isr = hit(addr, module_map_bit, PCS_ISR_OFS);
    wire logic sel_imr = hit(addr, module_map_bit, PCS_IMR_OFS);
    // user-level writes are ignored as well as reads
    wire logic wr_ok = wr && supervisor;
    wire logic wr_ctl = wr_ok && sel_ctl;
    wire logic wr_isr = wr_ok && sel_isr;
    wire logic wr_imr = wr_ok && sel_imr;

    logic [15:0] ctl_r;
    logic [15:0] ctl_nxt;
    logic [PCS_EV_N-1:0] isr_r;
    logic [PCS_EV_N-1:0] imr_r;
    logic [15:0] rdata_r;
    logic locked_q_r;
    pcs_src_t src_r;
    logic sys_rst_n_r;
    logic relock_r;
    logic [1:0] odiv_r;
    logic x_eff_r;
    logic sys_en_r;
    logic fb_r;

    wire logic w_bit = ctl_r[PCS_W_BIT];
    wire logic x_bit = ctl_r[PCS_X_BIT];
    wire logic [5:0] y_fld = ctl_r[PCS_Y_LSB +: PCS_Y_W];

    assign ctl_nxt = (wdata & PCS_CTL_WMASK) | (ctl_r & ~PCS_CTL_WMASK);
    // only the feedback bits disturb the loop; the output divider does not
    wire logic fb_change = wr_ctl &&
        ((ctl_nxt[PCS_W_BIT] != w_bit) ||
         (ctl_nxt[PCS_Y_LSB +: PCS_Y_W] != y_fld));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctl_r <= PCS_CTL_RST;
        else if (wr_ctl)
            ctl_r <= ctl_nxt;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            relock_r <= 1'b0;
        else
            relock_r <= fb_change;
    end

    // loop connections; relock also applies in the write cycle itself
    assign pll.vco_edge = pin_rise[PIN_VCO];
    assign pll.ref_edge = pin_rise[PIN_REF];
    assign pll.fb_w = w_bit;
    assign pll.fb_y = y_fld;
    assign pll.relock = relock_r || fb_change;

    pcs_fbdiv u_fbdiv (
        .clk(clk),
        .rst_n(rst_n),
        .pll(pll)
    );

    pcs_lockdet #(
        .WIN(PCS_LOCK_WIN),
        .GOOD(PCS_LOCK_GOOD)
    ) u_lockdet (
        .clk(clk),
        .rst_n(rst_n),
        .pll(pll)
    );

    // external source has no loop to wait for
    wire logic lock_now = (src_r == PCS_SRC_EXT) || pll.locked;

    // clock source latched only while the device is held in reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            src_r <= PCS_SRC_SYNTH;
        else if (!sys_rst_n_r && pins_valid)
            src_r <= pin_lvl[PIN_SRC] ? PCS_SRC_SYNTH : PCS_SRC_EXT;
    end

    // device reset released only once lock is shown
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sys_rst_n_r <= 1'b0;
        else if (lock_now)
            sys_rst_n_r <= 1'b1;
    end

    // output divider outside the loop; divide ratio taken at wrap only
    wire logic [1:0] odiv_last = x_eff_r ? PCS_ODIV_LAST_X1 : PCS_ODIV_LAST_X0;
    wire logic odiv_wrap = pll.vco_edge && (odiv_r == odiv_last);
    wire logic out_edge = (src_r == PCS_SRC_EXT) ? pll.ref_edge : odiv_wrap;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            odiv_r <= 2'h0;
            x_eff_r <= 1'b0;
            sys_en_r <= 1'b0;
        end
        else
        begin
            if (pll.vco_edge)
                odiv_r <= odiv_wrap ? 2'h0 : odiv_r + 2'h1;
            if (odiv_wrap)
                x_eff_r <= x_bit;
            sys_en_r <= out_edge;
        end
    end

    // interrupts: lock gained and lock lost, write one to clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            locked_q_r <= 1'b0;
        else
            locked_q_r <= lock_now;
    end

    wire logic [PCS_EV_N-1:0] ev = {locked_q_r && !lock_now,
                                    !locked_q_r && lock_now};
    wire logic [PCS_EV_N-1:0] isr_clr = wr_isr ? wdata[PCS_EV_N-1:0] : '0;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            isr_r <= PCS_EV_RST;
            imr_r <= PCS_EV_RST;
        end
        else
        begin
            // set beats clear when both fall in one cycle
            isr_r <= (isr_r & ~isr_clr) | ev;
            if (wr_imr)
                imr_r <= wdata[PCS_EV_N-1:0];
        end
    end

    // read data one cycle after the strobe; user level sees zero
    wire logic [15:0] ctl_view = {ctl_r[15:8], 4'h0, lock_now, 3'h0};
    wire logic [15:0] rd_mux =
        sel_ctl ? ctl_view :
        sel_isr ? {14'h0000, isr_r} :
        sel_imr ? {14'h0000, imr_r} : 16'h0000;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= 16'h0000;
        else if (rd)
            rdata_r <= supervisor ? rd_mux : 16'h0000;
        else
            rdata_r <= 16'h0000;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fb_r <= 1'b0;
        else
            fb_r <= pll.fb_pulse;
    end

    assign rdata = rdata_r;
    assign fb_compare = fb_r;
    assign sys_clk_en = sys_en_r;
    assign sys_rst_n = sys_rst_n_r;
    assign locked = lock_now;
    assign irq = |(isr_r & imr_r);

    // checks
    property p_user_read;
        @(posedge clk) disable iff (!rst_n)
        (rd && !supervisor) |=> (rdata == 16'h0000);
    endproperty
    a_user_read: assert property (p_user_read)
        else $error("user-level read returned register data");

    property p_lock_bit;
        @(posedge clk) disable iff (!rst_n)
        (rd && supervisor && sel_ctl)
            |=> (rdata[PCS_LOCK_BIT] == $past(lock_now));
    endproperty
    a_lock_bit: assert property (p_lock_bit)
        else $error("lock status bit disagrees with lock");

    property p_relock;
        @(posedge clk) disable iff (!rst_n)
        (fb_change && src_r == PCS_SRC_SYNTH) |=> !locked ##1 !locked;
    endproperty
    a_relock: assert property (p_relock)
        else $error("feedback change did not force relock");

    property p_x_only;
        @(posedge clk) disable iff (!rst_n)
        (wr_ctl && !fb_change && pll.locked && !pll.ref_edge)
            |=> pll.locked;
    endproperty
    a_x_only: assert property (p_x_only)
        else $error("output divider change dropped lock");

    property p_hold_reset;
        @(posedge clk) disable iff (!rst_n)
        (!lock_now && !sys_rst_n) |=> !sys_rst_n;
    endproperty
    a_hold_reset: assert property (p_hold_reset)
        else $error("device reset released before lock");

    property p_src_fixed;
        @(posedge clk) disable iff (!rst_n)
        (sys_rst_n && $past(sys_rst_n)) |-> $stable(src_r);
    endproperty
    a_src_fixed: assert property (p_src_fixed)
        else $error("clock source changed after reset release");

    property p_out_div;
        @(posedge clk) disable iff (!rst_n)
        (odiv_wrap && src_r == PCS_SRC_SYNTH)
            |=> sys_clk_en && (odiv_r == 2'h0);
    endproperty
    a_out_div: assert property (p_out_div)
        else $error("output divider wrap did not give a clock enable");

    property p_reset_value;
        @(posedge clk) disable iff (!rst_n)
        $rose(sys_rst_n) && !$past(wr_ctl, 2) && !$past(wr_ctl)
            |-> (ctl_r[15:8] == $past(ctl_r[15:8]));
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("control register changed without a write");

    property p_irq;
        @(posedge clk) disable iff (!rst_n)
        (ev[PCS_EV_LOCK] && imr_r[PCS_EV_LOCK] && !wr_imr) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked lock event raised no interrupt");
endmodule
`default_nettype wire

// file: tb/pcs_ref_model.sv
// pcs_ref_model: reference oscillator and vco stand-in for the synthesizer.
// assumes the bench sets ratio to the vco edges per reference period.
`default_nettype none
module pcs_ref_model
(
    input wire logic [11:0] ratio,
    output logic reference_clock_input,
    output logic vco_clk_in
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    // 50 MHz keeps the vco under what the sampled pin can follow;
    // offset by 1 ns so no edge lands on a system clock edge
    initial
    begin
        vco_clk_in = 1'b0;
        reference_clock_input = 1'b0;
        #1;
        forever #10 vco_clk_in = ~vco_clk_in;
    end
    // reference derived from vco edges: an exact ratio is what a locked
    // loop would settle to, so the count per window comes out even
    always @(posedge vco_clk_in)
    begin
        cnt = cnt + 1;
        if (cnt >= int'(ratio) / 2)
        begin
            cnt = 0;
            reference_clock_input = ~reference_clock_input;
        end
    end
endmodule
`default_nettype wire

// file: tb/pll_clock_synth_control_tb.sv
// pll_clock_synth_control_tb: register, divider, lock and reset checks.
// assumes pcs_top with its built-in assertions and the reference model.
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("Error t=%0t got=%0h exp=%0h", $time, got, exp); \
        end \
    end
module pll_clock_synth_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pcs_pkg::*;
    // clock cycles per vco edge: 20 ns vco against a 4 ns clock
    localparam int VCO_CYC = 5;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [PCS_AW-1:0] addr = '0;
    logic [PCS_DW-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic supervisor = 1'b1;
    logic mm = 1'b1;
    logic src_pin = 1'b1;
    logic [11:0] ratio = 12'h010;
    logic [PCS_DW-1:0] rdata;
    logic ref_clk;
    logic vco;
    logic fb_compare;
    logic sys_clk_en;
    logic sys_rst_n;
    logic locked;
    logic irq;
    int errors = 0;
    int n_checks = 0;

    always #2 clk = ~clk;

    pcs_ref_model partner (.ratio(ratio), .reference_clock_input(ref_clk),
        .vco_clk_in(vco));

    pcs_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .supervisor(supervisor),
        .module_map_bit(mm), .reference_clock_input(ref_clk),
        .vco_clk_in(vco), .clock_source_select_pin(src_pin),
        .fb_compare(fb_compare), .sys_clk_en(sys_clk_en),
        .sys_rst_n(sys_rst_n), .locked(locked), .irq(irq));

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    function automatic logic [23:0] at(input logic [19:0] ofs);
        return {mm, PCS_MAP_ONES, ofs};
    endfunction

    // expected output clock period in system clock cycles
    function automatic int sys_per(input int r, y, w, x);
        return r * VCO_CYC / (4 * (y + 1) * (2 ** (2 * w + x)));
    endfunction

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic wreg(input logic [23:0] a, input logic [15:0] d,
                        input logic s = 1'b1);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        supervisor <= s;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [23:0] a, input logic [15:0] e,
                        input logic s = 1'b1);
        @(posedge clk);
        addr <= a;
        supervisor <= s;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: return fb_compare;
            1: return sys_clk_en;
            2: return locked;
            default: return sys_rst_n;
        endcase
    endfunction

    // a wait that runs out of cycles is a failure in its own right
    task automatic wait_hi(input int s, input int bound);
        int i;
        i = 0;
        do
        begin
            tick;
            i++;
        end
        while (sig(s) !== 1'b1 && i < bound);
        if (sig(s) !== 1'b1)
        begin
            errors++;
            tally_and_finish;
        end
    endtask

    task automatic period(input int s, input int e);
        int k;
        wait_hi(s, 2000);
        tick;
        k = 1;
        while (sig(s) !== 1'b1 && k < 2000)
        begin
            tick;
            k++;
        end
        `CHK(k, e)
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rchk(at(PCS_CTL_OFS), 16'h3F00);
        `CHK(sys_rst_n, 1'b0)
        rchk(at(PCS_CTL_OFS), 16'h0000, 1'b0);
        wreg(at(PCS_CTL_OFS), 16'h0000, 1'b0);
        rchk(at(PCS_CTL_OFS), 16'h3F00);
        rchk({~mm, PCS_MAP_ONES, PCS_CTL_OFS}, 16'h0000);
        rchk(at(20'hFFA06), 16'h0000);
        // low bits are read-only: writing ones there must not show
        wreg(at(PCS_CTL_OFS), 16'h00FF);
        rchk(at(PCS_CTL_OFS), 16'h0000);
        `CHK(sys_rst_n, 1'b0)
        wait_hi(2, 20000);
        wait_hi(3, 4);
        rchk(at(PCS_CTL_OFS), 16'h0008);
        rchk(at(PCS_ISR_OFS), 16'h0001);
        `CHK(irq, 1'b0)
        wreg(at(PCS_IMR_OFS), 16'h0003);
        tick;
        `CHK(irq, 1'b1)
        wreg(at(PCS_ISR_OFS), 16'h0001);
        tick;
        `CHK(irq, 1'b0)
        period(0, 16 * VCO_CYC);
        period(1, 4 * VCO_CYC);
        wreg(at(PCS_CTL_OFS), 16'h4000);
        wait_hi(1, 100);
        period(1, sys_per(16, 0, 0, 1));
        period(1, 2 * VCO_CYC);
        `CHK(locked, 1'b1)
        rchk(at(PCS_CTL_OFS), 16'h4008);
        wreg(at(PCS_CTL_OFS), 16'hC000);
        tick;
        `CHK(locked, 1'b0)
        `CHK(irq, 1'b1)
        period(0, 64 * VCO_CYC);
        rchk(at(PCS_ISR_OFS), 16'h0002);
        @(posedge clk);
        ratio <= 12'd32;
        wreg(at(PCS_CTL_OFS), 16'h0100);
        wait_hi(2, 30000);
        period(0, 32 * VCO_CYC);
        period(1, sys_per(32, 1, 0, 0));
        rchk(at(PCS_ISR_OFS), 16'h0003);
        // second reset, external source and the other map nibble
        @(posedge clk);
        rst_n <= 1'b0;
        src_pin <= 1'b0;
        mm <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wait_hi(3, 12);
        `CHK(locked, 1'b1)
        @(posedge clk);
        src_pin <= 1'b1;
        repeat (8) tick;
        `CHK(locked, 1'b1)
        period(1, 32 * VCO_CYC);
        rchk(at(PCS_IMR_OFS), 16'h0000);
        // reset value again, lock bit set since the external source needs none
        rchk(at(PCS_CTL_OFS), PCS_CTL_RST | 16'h0008);
        rchk({~mm, PCS_MAP_ONES, PCS_CTL_OFS}, 16'h0000);
        tally_and_finish;
    end
endmodule
`undef CHK
`default_nettype wire
